// File: core/ccp_pkg.sv
// Shared constants and types for the capture/compare/PWM unit
package ccp_pkg;

   // =====================================================
   // Bus and register map (index, byte address = index * 4)
   localparam int ADDR_W = 10;
   localparam int UNITS = 2;
   localparam logic [7:0] IDX_PORT = 8'h07;
   localparam logic [7:0] IDX_DIR = 8'h87;
   localparam logic [7:0] IDX_TMR_L = 8'h0e;
   localparam logic [7:0] IDX_TMR_H = 8'h0f;
   localparam logic [7:0] IDX_TMR_CTL = 8'h10;
   localparam logic [7:0] IDX_FLAG [UNITS] = '{8'h0c, 8'h0d};
   localparam logic [7:0] IDX_CAP_L [UNITS] = '{8'h15, 8'h1b};
   localparam logic [7:0] IDX_CAP_H [UNITS] = '{8'h16, 8'h1c};
   localparam logic [7:0] IDX_CTL [UNITS] = '{8'h17, 8'h1d};

   // =====================================================
   // Field positions and reset values
   localparam logic [2:0] FLAG_BIT [UNITS] = '{3'h2, 3'h0};
   localparam logic [2:0] PIN_BIT [UNITS] = '{3'h2, 3'h1};
   localparam int TMR_RUN_BIT = 0;
   localparam int CTL_W = 6;
   localparam logic [CTL_W-1:0] CTL_RST = 6'h00;
   localparam logic [7:0] DIR_RST = 8'hff;
   localparam logic [15:0] TMR_RST = 16'h0000;
   localparam logic [3:0] PRE4_LAST = 4'h3;
   localparam logic [3:0] PRE16_LAST = 4'hf;

   // =====================================================
   // Mode codes of mode_select_field
   typedef enum logic [3:0] {
      MODE_OFF = 4'h0,
      MODE_CAP_FALL = 4'h4,
      MODE_CAP_RISE = 4'h5,
      MODE_CAP_RISE4 = 4'h6,
      MODE_CAP_RISE16 = 4'h7,
      MODE_CMP_SET = 4'h8,
      MODE_CMP_CLR = 4'h9,
      MODE_CMP_SOFT = 4'ha,
      MODE_CMP_SPECIAL = 4'hb
   } mode_e;

   // Bus answer state
   typedef enum logic {
      BUS_WAIT = 1'b0,
      BUS_DONE = 1'b1
   } bus_state_e;

   // Events raised by one unit
   typedef struct packed {
      logic cap;
      logic match;
      logic set_pin;
      logic clr_pin;
      logic special;
   } unit_evt_s;

endpackage

// File: core/cc_unit.sv
// One capture/compare channel: pin sampling, edge prescaler, match detect
`timescale 1ns/1ps
module cc_unit
   import ccp_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic [3:0] mode,
   input wire logic pin_in,
   input wire logic [15:0] timer,
   input wire logic [15:0] cmp,
   // Events
   output unit_evt_s evt
);

   logic sync1_reg, sync2_reg, prev_reg, seen_reg, seen_next;
   logic [3:0] pre_reg, pre_next, mode_reg;
   logic rise, fall, eq;

   // =====================================================
   // Edge detection, prescaler and compare
   always_comb
   begin
      rise = sync2_reg & ~prev_reg;
      fall = ~sync2_reg & prev_reg;
      pre_next = pre_reg;
      evt = '0;
      unique case (mode)
         MODE_CAP_FALL: evt.cap = fall;
         MODE_CAP_RISE: evt.cap = rise;
         MODE_CAP_RISE4, MODE_CAP_RISE16:
         begin
            if (rise)
            begin
               if (pre_reg == (mode == MODE_CAP_RISE4 ? PRE4_LAST : PRE16_LAST))
               begin
                  evt.cap = 1'b1;
                  pre_next = '0;
               end
               else
               begin
                  pre_next = pre_reg + 4'h1;
               end
            end
         end
         default: pre_next = '0;
      endcase
      // Mode change restarts the edge count
      if (mode != mode_reg)
      begin
         pre_next = '0;
      end
      eq = (mode[3:2] == 2'b10) && (timer == cmp);
      seen_next = eq;
      evt.match = eq & ~seen_reg;
      evt.set_pin = evt.match && (mode == MODE_CMP_SET);
      evt.clr_pin = evt.match && (mode == MODE_CMP_CLR);
      evt.special = evt.match && (mode == MODE_CMP_SPECIAL);
   end

   // Registers; pin passes two flops before use
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg <= 1'b0;
         pre_reg <= '0;
         mode_reg <= '0;
         seen_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
         pre_reg <= pre_next;
         mode_reg <= mode;
         seen_reg <= seen_next;
      end
   end

   // =====================================================
   // Checks
   chk_rise16_count: assert property (@(posedge pclk) disable iff (!presetn)
      (evt.cap && mode == MODE_CAP_RISE16 && $stable(mode)) |-> pre_reg == PRE16_LAST)
      else $error("sixteenth edge capture taken at wrong count");
   chk_match_equal: assert property (@(posedge pclk) disable iff (!presetn)
      evt.match |-> (timer == cmp && mode[3:2] == 2'b10))
      else $error("compare match without equality");
   chk_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == MODE_OFF) |=> (mode != MODE_OFF) || (pre_reg == '0 && evt == '0))
      else $error("disabled unit not idle");

endmodule

// File: core/capture_compare_pwm_unit.sv
// Two-channel capture/compare/PWM block with timer and APB register slave
//
// What this block does
// - A capture copies the whole 16-bit timer count into the capture pair.
// - Modes capture on falling, rising, fourth rising or sixteenth rising edge.
// - Control bits 3:0 choose the capture event type.
// - Compare match sets flag; set, clear or leave the pin by mode.
// - Special event mode match sets flag and clears the timer.
// - Control bits 5:4 hold the duty low bits, unused outside PWM.
// - Control bits 7:6 always read zero.
// - A capture sets the capture flag at its flag bit.
// - A new capture overwrites the pair, losing the old value.
// - With the pin as output, a port write may cause a capture.
// - Changing capture mode may set the capture flag spuriously.
`timescale 1ns/1ps
module capture_compare_pwm_unit
   import ccp_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Capture pins, one per unit
   input wire logic [UNITS-1:0] pin_in,
   output logic [UNITS-1:0] pin_out,
   output logic [UNITS-1:0] pin_oe
);

   // =====================================================
   // State
   bus_state_e bus_reg, bus_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pslverr_reg, pslverr_next;
   logic [CTL_W-1:0] ctl_reg [UNITS];
   logic [CTL_W-1:0] ctl_next [UNITS];
   logic [15:0] cap_reg [UNITS];
   logic [15:0] cap_next [UNITS];
   logic [UNITS-1:0] flag_reg, flag_next, cmp_out_reg, cmp_out_next;
   logic [UNITS-1:0] pin_out_reg, pin_out_next, pin_oe_reg, pin_oe_next;
   logic [15:0] timer_reg, timer_next;
   logic run_reg, run_next;
   logic [7:0] port_reg, port_next, dir_reg, dir_next;
   unit_evt_s evt [UNITS];
   logic [7:0] idx;
   logic access, wr, rd, any_special;

   // Known register index
   function automatic logic reg_hit(input logic [7:0] i);
      logic h;
      h = (i == IDX_PORT) || (i == IDX_DIR) || (i == IDX_TMR_L) || (i == IDX_TMR_H)
         || (i == IDX_TMR_CTL);
      for (int u = 0; u < UNITS; u++)
      begin
         h = h || (i == IDX_FLAG[u]) || (i == IDX_CAP_L[u]) || (i == IDX_CAP_H[u])
            || (i == IDX_CTL[u]);
      end
      return h;
   endfunction

   // =====================================================
   // Channels
   for (genvar g = 0; g < UNITS; g++)
   begin : unit_gen
      cc_unit u_unit (
         .pclk(pclk),
         .presetn(presetn),
         .mode(ctl_reg[g][3:0]),
         .pin_in(pin_in[g]),
         .timer(timer_reg),
         .cmp(cap_reg[g]),
         .evt(evt[g])
      );
   end

   // =====================================================
   // APB handshake: answer one cycle into the access phase
   always_comb
   begin
      idx = paddr[ADDR_W-1:2];
      access = psel && penable;
      bus_next = (access && bus_reg == BUS_WAIT) ? BUS_DONE : BUS_WAIT;
      // Misaligned or unmapped writes are refused; misaligned reads return zero
      wr = access && bus_reg == BUS_DONE && pwrite && pstrb[0] && reg_hit(idx)
         && (paddr[1:0] == 2'b00);
      rd = access && bus_reg == BUS_WAIT && !pwrite && (paddr[1:0] == 2'b00);
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;
      if (access && bus_reg == BUS_WAIT)
      begin
         pslverr_next = !reg_hit(idx) || (paddr[1:0] != 2'b00);
         prdata_next = '0;
      end
      // Read data mux
      if (rd)
      begin
         unique case (1'b1)
            idx == IDX_PORT: prdata_next[7:0] = port_reg;
            idx == IDX_DIR: prdata_next[7:0] = dir_reg;
            idx == IDX_TMR_L: prdata_next[7:0] = timer_reg[7:0];
            idx == IDX_TMR_H: prdata_next[7:0] = timer_reg[15:8];
            idx == IDX_TMR_CTL: prdata_next[TMR_RUN_BIT] = run_reg;
            default:
            begin
               for (int u = 0; u < UNITS; u++)
               begin
                  if (idx == IDX_FLAG[u])
                  begin
                     prdata_next[FLAG_BIT[u]] = flag_reg[u];
                  end
                  if (idx == IDX_CAP_L[u])
                  begin
                     prdata_next[7:0] = cap_reg[u][7:0];
                  end
                  if (idx == IDX_CAP_H[u])
                  begin
                     prdata_next[7:0] = cap_reg[u][15:8];
                  end
                  if (idx == IDX_CTL[u])
                  begin
                     prdata_next[7:0] = {2'b00, ctl_reg[u]};
                  end
               end
            end
         endcase
      end
   end

   // =====================================================
   // Timer, port and channel registers
   always_comb
   begin
      any_special = 1'b0;
      run_next = run_reg;
      port_next = port_reg;
      dir_next = dir_reg;
      timer_next = run_reg ? timer_reg + 16'h0001 : timer_reg;
      for (int u = 0; u < UNITS; u++)
      begin
         any_special = any_special | evt[u].special;
      end
      if (any_special)
      begin
         timer_next = TMR_RST;
      end
      if (wr && idx == IDX_TMR_L)
      begin
         timer_next[7:0] = pwdata[7:0];
      end
      if (wr && idx == IDX_TMR_H)
      begin
         timer_next[15:8] = pwdata[7:0];
      end
      if (wr && idx == IDX_TMR_CTL)
      begin
         run_next = pwdata[TMR_RUN_BIT];
      end
      if (wr && idx == IDX_PORT)
      begin
         port_next = pwdata[7:0];
      end
      if (wr && idx == IDX_DIR)
      begin
         dir_next = pwdata[7:0];
      end
      for (int u = 0; u < UNITS; u++)
      begin
         ctl_next[u] = ctl_reg[u];
         cap_next[u] = cap_reg[u];
         flag_next[u] = flag_reg[u];
         cmp_out_next[u] = cmp_out_reg[u];
         if (wr && idx == IDX_CTL[u])
         begin
            ctl_next[u] = pwdata[CTL_W-1:0];
         end
         if (wr && idx == IDX_CAP_L[u])
         begin
            cap_next[u][7:0] = pwdata[7:0];
         end
         if (wr && idx == IDX_CAP_H[u])
         begin
            cap_next[u][15:8] = pwdata[7:0];
         end
         // Capture wins over a software write
         if (evt[u].cap)
         begin
            cap_next[u] = timer_reg;
         end
         if (wr && idx == IDX_FLAG[u])
         begin
            flag_next[u] = pwdata[FLAG_BIT[u]];
         end
         // Set wins over clear
         if (evt[u].cap || evt[u].match)
         begin
            flag_next[u] = 1'b1;
         end
         if (evt[u].set_pin)
         begin
            cmp_out_next[u] = 1'b1;
         end
         if (evt[u].clr_pin)
         begin
            cmp_out_next[u] = 1'b0;
         end
         if (ctl_reg[u][3:0] == MODE_OFF)
         begin
            cmp_out_next[u] = 1'b0;
         end
         // Pin drive: compare output in set/clear modes, else port latch
         if (ctl_reg[u][3:0] == MODE_CMP_SET || ctl_reg[u][3:0] == MODE_CMP_CLR)
         begin
            pin_out_next[u] = cmp_out_next[u];
         end
         else
         begin
            pin_out_next[u] = port_next[PIN_BIT[u]];
         end
         pin_oe_next[u] = ~dir_next[PIN_BIT[u]];
      end
   end

   // Register all state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_reg <= BUS_WAIT;
         prdata_reg <= '0;
         pslverr_reg <= 1'b0;
         timer_reg <= TMR_RST;
         run_reg <= 1'b0;
         port_reg <= '0;
         dir_reg <= DIR_RST;
         flag_reg <= '0;
         cmp_out_reg <= '0;
         pin_out_reg <= '0;
         pin_oe_reg <= '0;
         for (int u = 0; u < UNITS; u++)
         begin
            ctl_reg[u] <= CTL_RST;
            cap_reg[u] <= '0;
         end
      end
      else
      begin
         bus_reg <= bus_next;
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
         timer_reg <= timer_next;
         run_reg <= run_next;
         port_reg <= port_next;
         dir_reg <= dir_next;
         flag_reg <= flag_next;
         cmp_out_reg <= cmp_out_next;
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
         for (int u = 0; u < UNITS; u++)
         begin
            ctl_reg[u] <= ctl_next[u];
            cap_reg[u] <= cap_next[u];
         end
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_reg;
   assign pready = bus_reg == BUS_DONE;
   assign pslverr = pslverr_reg;
   assign pin_out = pin_out_reg;
   assign pin_oe = pin_oe_reg;

   // =====================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_capture_copy: assert property (evt[0].cap |=> cap_reg[0] == $past(timer_reg))
      else $error("capture pair does not hold timer value");
   chk_flag_set: assert property ((evt[1].cap || evt[1].match) |=> flag_reg[1])
      else $error("flag not set after event");
   chk_special_reset: assert property (
      (evt[0].special && !(wr && (idx == IDX_TMR_L || idx == IDX_TMR_H)))
      |=> timer_reg == TMR_RST)
      else $error("special event did not clear timer");
   chk_ctl_top_zero: assert property ((rd && idx == IDX_CTL[0]) |=> prdata[7:6] == 2'b00)
      else $error("unimplemented control bits read nonzero");
   chk_pin_set: assert property (evt[0].set_pin |=> pin_out[0])
      else $error("pin not driven high on match");

   cov_capture: cover property (evt[0].cap ##[1:20] evt[0].cap);
   cov_special: cover property (evt[1].special);
   cov_clear: cover property (evt[0].clr_pin ##1 !pin_out[0]);

endmodule

// File: dv/pin_source.sv
// External signal source on the capture pins, resolved with the block's drive
`timescale 1ns/1ps
module pin_source
   import ccp_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Drive from the block
   input wire logic [UNITS-1:0] pin_out,
   input wire logic [UNITS-1:0] pin_oe,
   // Resolved pin level
   output logic [UNITS-1:0] pin_in
);
   logic [UNITS-1:0] lvl = '0;

   // Block wins while it drives, so a port write can reach the pin
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl);

   // Pulse trains, prompt or slow by hold length
   task pulses(input int u, input int n, input int hold);
      repeat (n)
      begin
         @(posedge pclk);
         lvl[u] <= 1'b1;
         repeat (hold) @(posedge pclk);
         lvl[u] <= 1'b0;
         repeat (hold - 1) @(posedge pclk);
      end
   endtask
endmodule

// File: dv/capture_compare_pwm_unit_bench.sv
// Self-checking bench for the capture/compare/PWM block
`timescale 1ns/1ps
module capture_compare_pwm_unit_bench;
   import ccp_pkg::*;

   // =====================================
   // Signals and model state
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [UNITS-1:0] pin_in;
   logic [UNITS-1:0] pin_out;
   logic [UNITS-1:0] pin_oe;
   logic [31:0] bus_rd;
   logic bus_err;
   logic [15:0] tv;
   int mismatches = 0;
   int num_checks = 0;
   int seed = 29437;
   int mdl [256];

   // Clock
   always #20 pclk = ~pclk;

   // Block and far-side source
   capture_compare_pwm_unit capture_compare_pwm_unit_i (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   pin_source pin_source_i (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

   // =====================================
   // Checking and closing
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // =====================================
   // Bus master and register model
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
      input logic [3:0] st);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'($random(seed)), d};
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1);
      chk_word("bus wait cycles", 32'd2, 32'(n));
      bus_rd = prdata;
      bus_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic int mask_of(input logic [7:0] idx);
      int m;
      m = 255;
      for (int u = 0; u < UNITS; u++)
      begin
         if (idx == IDX_CTL[u])
            m = 8'h3f;
         if (idx == IDX_FLAG[u])
            m = 1 << FLAG_BIT[u];
      end
      return m;
   endfunction

   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, {idx, 2'b00}, d, 4'hf);
      mdl[idx] = d & mask_of(idx);
      chk_bit("write error", 1'b0, bus_err);
   endtask

   task automatic reg_rd(input logic [7:0] idx);
      apb(1'b0, {idx, 2'b00}, 8'h00, 4'h0);
      chk_word($sformatf("reg %h", idx), 32'(mdl[idx]), bus_rd);
   endtask

   task automatic set_timer(input logic [15:0] t);
      reg_wr(IDX_TMR_L, t[7:0]);
      reg_wr(IDX_TMR_H, t[15:8]);
   endtask

   task automatic expect_cap(input int u, input logic [15:0] t);
      mdl[IDX_CAP_L[u]] = t[7:0];
      mdl[IDX_CAP_H[u]] = t[15:8];
      mdl[IDX_FLAG[u]] = mask_of(IDX_FLAG[u]);
      reg_rd(IDX_CAP_L[u]);
      reg_rd(IDX_CAP_H[u]);
      reg_rd(IDX_FLAG[u]);
   endtask

   // Capture after n edges with a stopped timer, none one edge earlier
   task automatic cap_test(input int u, input logic [3:0] m, input int n);
      logic [15:0] t;
      t = 16'($random(seed));
      set_timer(t);
      reg_wr(IDX_CTL[u], {4'h0, m});
      reg_wr(IDX_FLAG[u], 8'h00);
      pin_source_i.pulses(u, n - 1, 1 + ($unsigned($random(seed)) % 4));
      reg_rd(IDX_FLAG[u]);
      pin_source_i.pulses(u, 1, 3);
      cyc(4);
      expect_cap(u, t);
   endtask

   // Timer runs through the compare value once
   task automatic cmp_test(input int u, input logic [3:0] m, input logic pin);
      logic [15:0] v;
      v = 16'($random(seed)) | 16'h8000;
      reg_wr(IDX_CTL[u], 8'h00); // Park unit so loading timer and pair cannot match
      set_timer(v - 16'h0014);
      reg_wr(IDX_CAP_L[u], v[7:0]);
      reg_wr(IDX_CAP_H[u], v[15:8]);
      reg_wr(IDX_CTL[u], {4'h0, m});
      reg_wr(IDX_FLAG[u], 8'h00);
      reg_wr(IDX_TMR_CTL, 8'h01);
      cyc(30);
      reg_wr(IDX_TMR_CTL, 8'h00);
      mdl[IDX_FLAG[u]] = mask_of(IDX_FLAG[u]);
      reg_rd(IDX_FLAG[u]);
      @(negedge pclk);
      chk_bit("compare pin", pin, pin_out[u]);
      mdl[IDX_TMR_H] = 0;
      if (m == MODE_CMP_SPECIAL)
         reg_rd(IDX_TMR_H);
   endtask

   // =====================================
   // Main sequence
   initial
   begin
      foreach (mdl[i])
         mdl[i] = 0;
      mdl[IDX_DIR] = 8'hff;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      reg_rd(IDX_DIR);
      for (int u = 0; u < UNITS; u++)
      begin
         reg_rd(IDX_CTL[u]);
         reg_rd(IDX_FLAG[u]);
         reg_rd(IDX_CAP_H[u]);
         repeat (4) reg_wr(IDX_CTL[u], 8'($random(seed)) | 8'h0c);
         reg_rd(IDX_CTL[u]);
         reg_wr(IDX_CTL[u], 8'h00);
      end
      apb(1'b0, {8'h40, 2'b00}, 8'h00, 4'h0);
      chk_bit("unmapped error", 1'b1, bus_err);
      chk_word("unmapped data", 32'h0000_0000, bus_rd);
      apb(1'b1, {IDX_CTL[0], 2'b01}, 8'h05, 4'hf);
      chk_bit("misaligned error", 1'b1, bus_err);
      apb(1'b1, {IDX_CTL[0], 2'b00}, 8'h05, 4'he);
      reg_rd(IDX_CTL[0]);
      for (int u = 0; u < UNITS; u++)
         for (int k = 0; k < 4; k++)
            cap_test(u, 4'(MODE_CAP_FALL + k), k < 2 ? 1 : (k == 2 ? 4 : 16));
      reg_wr(IDX_CTL[0], 8'h00);
      reg_wr(IDX_FLAG[0], 8'h00);
      pin_source_i.pulses(0, 2, 2);
      cyc(4);
      reg_rd(IDX_FLAG[0]);
      reg_rd(IDX_CAP_L[0]);
      tv = 16'($random(seed));
      set_timer(tv);
      reg_wr(IDX_CTL[0], 8'h05);
      reg_wr(IDX_DIR, 8'hff ^ (8'h01 << PIN_BIT[0]));
      reg_wr(IDX_FLAG[0], 8'h00);
      reg_wr(IDX_PORT, 8'hff);
      cyc(4);
      expect_cap(0, tv);
      reg_wr(IDX_PORT, 8'h00);
      for (int u = 0; u < UNITS; u++)
      begin
         reg_wr(IDX_DIR, 8'hff ^ (8'h01 << PIN_BIT[u]));
         for (int k = 0; k < 4; k++)
            cmp_test(u, 4'(MODE_CMP_SPECIAL - k), k == 3);
         reg_wr(IDX_CTL[u], 8'h00);
         cyc(1); // Pin leaves compare drive one edge after the mode write
         @(negedge pclk);
         chk_bit("pin after off", 1'b0, pin_out[u]);
         chk_bit("pin drive", 1'b1, pin_oe[u]);
      end
      wrap_up();
   end

   // Watchdog
   initial
   begin
      repeat (30000) @(posedge pclk);
      mismatches++;
      $display("BAD watchdog expected done seen hung");
      wrap_up();
   end
endmodule
